// ### adc_seq_pkg.sv
/*
  package for the converter sequencer: register indices, field positions,
  reset values, modes, trigger sources, state encodings and carrier structs.
  assumes a plain register port with one-cycle read latency.
*/
package adc_seq_pkg;

  // register indices (port address = index)
  localparam logic [3:0] IDX_CTRL_STATUS = 4'h0;
  localparam logic [3:0] IDX_CONTROL = 4'h1;
  localparam logic [3:0] IDX_PLACEMENT = 4'h2;
  localparam logic [3:0] IDX_SAMPLE_LEN = 4'h3;
  localparam logic [3:0] IDX_SELF_CHECK = 4'h4;
  localparam logic [3:0] IDX_MODULE_STOP = 4'h5;
  localparam logic [3:0] IDX_RESULT_FIRST = 4'h8;
  localparam int NUM_CH = 4;
  localparam int RES_BITS = 10;

  // conv_ctrl_status_reg fields
  localparam int CS_CH_LSB = 0; // [1:0] highest channel of a scan, or channel for single
  localparam int CS_START = 5; // conversion_start_bit
  localparam int CS_DONE_IE = 6; // done_irq_enable
  localparam int CS_DONE_FLAG = 7; // sticky completion flag, write 0 clears
  // conv_control_reg fields
  localparam int CR_MODE_LSB = 0; // [1:0]
  localparam int CR_CLKSEL_LSB = 2; // [3:2] clock_divider_select
  localparam int CR_TRIG_LSB = 5; // [7:5]
  // other single bits and the two-bit level field
  localparam int PL_LEFT = 7;
  localparam int SC_ENABLE = 0;
  localparam int SC_LEVEL_LSB = 1; // [2:1]

  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_PLACEMENT = 8'h00; // right justified
  localparam logic [7:0] RST_SAMPLE_LEN = 8'h19;
  localparam logic [7:0] RST_SELF_CHECK = 8'h00;
  localparam logic RST_MODULE_STOP = 1'b1;

  // cycles of one conversion-clock tick spent per result bit
  localparam logic [3:0] BIT_STATES = 4'h2;

  typedef enum logic [1:0]
  {
    MODE_SINGLE = 2'b00,
    MODE_ONE_PASS = 2'b01,
    MODE_CONTINUOUS = 2'b10
  } conv_mode_t;

  typedef enum logic [2:0]
  {
    TRIG_SOFTWARE = 3'b000,
    TRIG_EXT_PIN = 3'b001,
    TRIG_MULTIFUNCTION_TIMER = 3'b010,
    TRIG_EIGHT_BIT_TIMER = 3'b011
  } trig_src_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10,
    ST_STORE = 2'b11
  } conv_state_t;

  // register bus request
  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // hand-off from the approximation core
  typedef struct packed
  {
    logic busy;
    logic done;
    logic [RES_BITS-1:0] code;
  } sar_out_t;

endpackage

// ### adc_sar_core.sv
/*
  successive-approximation search over ten bits, paced by the conversion tick.
  assumes a comparator result input that is synchronous to i_core_clk.
*/
`timescale 1ns/1ps
module adc_sar_core
  import adc_seq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_go,
  input wire logic i_tick,
  input wire logic i_cmp_above,
  output adc_seq_pkg::sar_out_t o_sar
);

  typedef struct packed
  {
    logic busy;
    logic done;
    logic [RES_BITS-1:0] code;
    logic [RES_BITS-1:0] probe;
    logic [3:0] ticks;
  } sar_state_t;

  sar_state_t state_reg;
  sar_state_t state_next;

  // one trial bit per BIT_STATES ticks; the probe walks msb to lsb
  // the code flops carry the trial value itself, so the dac code needs no gate after the flops
  always_comb
  begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (i_go)
    begin
      state_next.busy = 1'b1;
      state_next.code = {1'b1, {(RES_BITS-1){1'b0}}};
      state_next.probe = {1'b1, {(RES_BITS-1){1'b0}}};
      state_next.ticks = '0;
    end
    else if (state_reg.busy && i_tick)
    begin
      state_next.ticks = state_reg.ticks + 4'h1;
      if (state_reg.ticks == BIT_STATES - 4'h1)
      begin
        state_next.ticks = '0;
        // keep the bit under test when the input stands above the trial, then raise the next bit
        state_next.code = (i_cmp_above ? state_reg.code : state_reg.code & ~state_reg.probe) |
          (state_reg.probe >> 1);
        state_next.probe = state_reg.probe >> 1;
        if (state_reg.probe[0])
        begin
          state_next.busy = 1'b0;
          state_next.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_sar = '{busy: state_reg.busy, done: state_reg.done, code: state_reg.code};

endmodule

// ### adc_sequencer_control.sv
/*
  control of a 10-bit successive-approximation converter: triggers, modes,
  clock post-scaler, sampling length, result placement, done interrupt and
  module stop. assumes a comparator on the analog side, timer trigger pulses
  on i_core_clk, and an asynchronous external trigger pin.
*/
// The plain strobed port and the register addresses were chosen for this implementation.
//
// Contract
// [R1] done interrupt request goes out only while done_irq_enable is set
// [R2] software also enables and prioritises the source in the interrupt controller
// [R3] writing one to start bit begins conversion; bit reads one until done
// [R4] two-bit clock_divider_select picks the post-scaled conversion clock
// [R5] choices are peripheral clock divided by one, two, four or eight
// [R6] sample_length_reg sets sampling length in conversion-clock states
// [R7] each conversion gives a ten-bit result
// [R8] result_placement_reg selects left or right justified results
// [R9] placement resets to right justified
// [R10] start from software, external pin, multifunction timer or eight-bit timer
// [R11] modes: single shot, one-pass sweep, continuous scan
// [R12] scans always begin at analog_input_zero
// [R13] converter idles unpowered until module_stop_bit is cleared
// [R14] self_check_reg converts internal reference levels instead of inputs
// [R15] continuous keeps start set; done raised at end of each sequence
// [R16] each channel result has its own register, channel zero first
`timescale 1ns/1ps
module adc_sequencer_control
  import adc_seq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ext_trigger_pin_n,
  input wire logic i_multifunction_timer_trig,
  input wire logic i_eight_bit_timer_trig,
  input wire logic i_cmp_above,
  output logic [15:0] o_rdata,
  output logic o_done_irq,
  output logic o_analog_power_en,
  output logic o_sample_hold,
  output logic [1:0] o_mux_sel,
  output logic o_mux_ref_sel,
  output logic [1:0] o_ref_level_sel,
  output logic [RES_BITS-1:0] o_dac_code
);

  typedef struct packed
  {
    logic [7:0] ctrl_status;
    logic [7:0] control;
    logic [7:0] placement;
    logic [7:0] sample_len;
    logic [7:0] self_check;
    logic module_stop;
    logic [NUM_CH-1:0][RES_BITS-1:0] result;
    conv_state_t phase;
    logic [1:0] channel;
    logic [7:0] sample_cnt;
    logic [2:0] prescale;
    logic tick;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic sar_go;
    logic [15:0] rdata;
    logic irq;
    logic power_en;
    logic sample_hold;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;
  sar_out_t sar;
  logic pin_fall;
  logic trig_hit;
  logic [2:0] div_mask;
  logic [15:0] rd_word;
  logic [NUM_CH-1:0][15:0] placed;
  conv_mode_t mode;
  trig_src_t trig;

  adc_sar_core u_sar
  (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_go(state_reg.sar_go),
    .i_tick(state_reg.tick),
    .i_cmp_above(i_cmp_above),
    .o_sar(sar)
  );

  assign mode = conv_mode_t'(state_reg.control[CR_MODE_LSB +: 2]);
  assign trig = trig_src_t'(state_reg.control[CR_TRIG_LSB +: 3]);
  // pin edge looks only at the second synchroniser stage and its delayed copy
  // the synchroniser holds the inverted pin, so a falling pin shows as a rising sample
  assign pin_fall = ~state_reg.pin_prev & state_reg.pin_sync[1];

  // hardware triggers count only while idle; a trigger mid-sequence is dropped
  always_comb
  begin
    unique case (trig)
      TRIG_EXT_PIN: trig_hit = pin_fall; // R10
      TRIG_MULTIFUNCTION_TIMER: trig_hit = i_multifunction_timer_trig; // R10
      TRIG_EIGHT_BIT_TIMER: trig_hit = i_eight_bit_timer_trig; // R10
      default: trig_hit = 1'b0;
    endcase
  end

  // post-scaler mask: tick when the low counter bits are all zero
  always_comb
  begin
    unique case (state_reg.control[CR_CLKSEL_LSB +: 2])
      2'b00: div_mask = 3'h7; // R5 divide by eight
      2'b01: div_mask = 3'h3; // R5 divide by four
      2'b10: div_mask = 3'h1; // R5 divide by two
      default: div_mask = 3'h0; // R5 undivided
    endcase
  end

  // per-channel justification
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_place
      assign placed[g] = state_reg.placement[PL_LEFT] ?
        {state_reg.result[g], 6'h00} : {6'h00, state_reg.result[g]}; // R8
    end
  endgenerate

  // read mux
  always_comb
  begin
    rd_word = 16'h0000;
    if (i_addr >= IDX_RESULT_FIRST && i_addr < IDX_RESULT_FIRST + 4'(NUM_CH))
    begin
      rd_word = placed[i_addr[1:0]]; // R16
    end
    else
    begin
      unique case (i_addr)
        IDX_CTRL_STATUS: rd_word = {8'h00, state_reg.ctrl_status};
        IDX_CONTROL: rd_word = {8'h00, state_reg.control};
        IDX_PLACEMENT: rd_word = {8'h00, state_reg.placement};
        IDX_SAMPLE_LEN: rd_word = {8'h00, state_reg.sample_len};
        IDX_SELF_CHECK: rd_word = {8'h00, state_reg.self_check};
        IDX_MODULE_STOP: rd_word = {15'h0000, state_reg.module_stop};
        default: rd_word = 16'h0000;
      endcase
    end
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.sar_go = 1'b0;
    state_next.pin_sync = {state_reg.pin_sync[0], ~i_ext_trigger_pin_n};
    state_next.pin_prev = state_reg.pin_sync[1];
    state_next.rdata = i_rd ? rd_word : 16'h0000;
    // conversion clock divides the peripheral clock only while powered
    state_next.prescale = state_reg.prescale + 3'h1;
    state_next.tick = ((state_reg.prescale & div_mask) == 3'h0) && !state_reg.module_stop; // R4

    // register writes
    if (i_wr)
    begin
      unique case (i_addr)
        IDX_CTRL_STATUS:
        begin
          state_next.ctrl_status[CS_CH_LSB +: 2] = i_wdata[CS_CH_LSB +: 2];
          state_next.ctrl_status[CS_DONE_IE] = i_wdata[CS_DONE_IE];
          if (!i_wdata[CS_DONE_FLAG])
          begin
            state_next.ctrl_status[CS_DONE_FLAG] = 1'b0;
          end
          if (i_wdata[CS_START] && !state_reg.module_stop)
          begin
            state_next.ctrl_status[CS_START] = 1'b1; // R3 R13
          end
          else if (!i_wdata[CS_START])
          begin
            state_next.ctrl_status[CS_START] = 1'b0; // R15 software stop
            state_next.phase = ST_IDLE;
          end
        end
        IDX_CONTROL: state_next.control = i_wdata;
        IDX_PLACEMENT: state_next.placement = i_wdata & 8'h80;
        IDX_SAMPLE_LEN: state_next.sample_len = i_wdata; // R6
        IDX_SELF_CHECK: state_next.self_check = i_wdata & 8'h07; // R14
        IDX_MODULE_STOP: state_next.module_stop = i_wdata[0]; // R13
        default: state_next.module_stop = state_reg.module_stop;
      endcase
    end

    // hardware trigger sets the start bit like a software write
    if (state_reg.phase == ST_IDLE && trig_hit && !state_reg.module_stop
        && !state_reg.ctrl_status[CS_START])
    begin
      state_next.ctrl_status[CS_START] = 1'b1; // R10
    end

    // sequencer
    unique case (state_reg.phase)
      ST_IDLE:
      begin
        if (state_reg.ctrl_status[CS_START] && !state_reg.module_stop)
        begin
          state_next.phase = ST_SAMPLE;
          state_next.sample_cnt = '0;
          state_next.channel = (mode == MODE_SINGLE) ? state_reg.ctrl_status[CS_CH_LSB +: 2] : 2'b00; // R11 R12
        end
      end
      ST_SAMPLE:
      begin
        if (state_reg.tick)
        begin
          state_next.sample_cnt = state_reg.sample_cnt + 8'h01;
          if (state_reg.sample_cnt + 8'h01 >= state_reg.sample_len)
          begin
            state_next.phase = ST_CONVERT; // R6
            state_next.sar_go = 1'b1;
          end
        end
      end
      ST_CONVERT:
      begin
        if (sar.done)
        begin
          state_next.phase = ST_STORE;
          state_next.result[state_reg.channel] = sar.code; // R7 R16
        end
      end
      ST_STORE:
      begin
        if (mode != MODE_SINGLE && state_reg.channel != state_reg.ctrl_status[CS_CH_LSB +: 2])
        begin
          state_next.channel = state_reg.channel + 2'b01; // R11
          state_next.phase = ST_SAMPLE;
          state_next.sample_cnt = '0;
        end
        else
        begin
          state_next.ctrl_status[CS_DONE_FLAG] = 1'b1; // R15 set beats clear
          if (mode == MODE_CONTINUOUS)
          begin
            state_next.channel = 2'b00; // R12 R15
            state_next.phase = ST_SAMPLE;
            state_next.sample_cnt = '0;
          end
          else
          begin
            state_next.ctrl_status[CS_START] = 1'b0; // R3
            state_next.phase = ST_IDLE;
          end
        end
      end
    endcase

    // a software stop written this cycle outranks the sequencer
    if (i_wr && i_addr == IDX_CTRL_STATUS && !i_wdata[CS_START])
    begin
      state_next.phase = ST_IDLE;
      state_next.ctrl_status[CS_START] = 1'b0;
    end
    if (state_next.module_stop)
    begin
      state_next.phase = ST_IDLE; // R13
      state_next.ctrl_status[CS_START] = 1'b0;
    end
    // restart the post-scaler as sampling begins; a free-running one would cut the first state short
    if (state_next.phase == ST_SAMPLE && state_reg.phase != ST_SAMPLE)
    begin
      state_next.prescale = 3'h2;
      state_next.tick = (div_mask == 3'h0); // R6
    end
    state_next.irq = state_next.ctrl_status[CS_DONE_FLAG] & state_next.ctrl_status[CS_DONE_IE]; // R1
    state_next.power_en = ~state_next.module_stop; // R13
    state_next.sample_hold = (state_next.phase == ST_SAMPLE);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state_reg <= '0;
      state_reg.ctrl_status <= RST_CTRL_STATUS;
      state_reg.control <= RST_CONTROL;
      state_reg.placement <= RST_PLACEMENT; // R9
      state_reg.sample_len <= RST_SAMPLE_LEN;
      state_reg.self_check <= RST_SELF_CHECK;
      state_reg.module_stop <= RST_MODULE_STOP;
      state_reg.phase <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // analog-facing controls come straight from state flops or the core flops
  assign o_rdata = state_reg.rdata;
  assign o_done_irq = state_reg.irq;
  assign o_analog_power_en = state_reg.power_en; // R13
  assign o_sample_hold = state_reg.sample_hold;
  assign o_mux_sel = state_reg.channel;
  assign o_mux_ref_sel = state_reg.self_check[SC_ENABLE]; // R14
  assign o_ref_level_sel = state_reg.self_check[SC_LEVEL_LSB +: 2];
  assign o_dac_code = sar.code;

endmodule

// ### adc_seq_sva.sv
/*
  checker for the sequencer top: ties outputs to register writes seen at the ports.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module adc_seq_sva
  import adc_seq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_done_irq,
  input wire logic o_analog_power_en,
  input wire logic o_sample_hold,
  input wire logic [1:0] o_mux_sel
);
  logic [7:0] len_sh;
  logic [1:0] clk_sh;
  logic [2:0] trig_sh;
  logic stop_sh;
  logic ie_sh;
  logic [11:0] cnt;
  logic [7:0] eff;
  logic wr0;
  logic rd_len;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // zero length behaves as one tick
  assign wr0 = i_wr && (i_addr == IDX_CTRL_STATUS);
  assign rd_len = i_rd && (i_addr == IDX_SAMPLE_LEN);
  assign eff = (len_sh == 8'h00) ? 8'h01 : len_sh;
  // shadows of settings, and the length of the current sampling phase
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      len_sh <= RST_SAMPLE_LEN;
      clk_sh <= RST_CONTROL[3:2];
      trig_sh <= RST_CONTROL[7:5];
      stop_sh <= RST_MODULE_STOP;
      ie_sh <= RST_CTRL_STATUS[CS_DONE_IE];
      cnt <= 12'h000;
    end
    else
    begin
      if (i_wr && i_addr == IDX_SAMPLE_LEN)
        len_sh <= i_wdata;
      if (i_wr && i_addr == IDX_CONTROL)
        clk_sh <= i_wdata[CR_CLKSEL_LSB +: 2];
      if (i_wr && i_addr == IDX_CONTROL)
        trig_sh <= i_wdata[CR_TRIG_LSB +: 3];
      if (i_wr && i_addr == IDX_MODULE_STOP)
        stop_sh <= i_wdata[0];
      if (wr0)
        ie_sh <= i_wdata[CS_DONE_IE];
      cnt <= o_sample_hold ? cnt + 12'h001 : 12'h000;
    end
  end
  a_irq_gated: assert property ($rose(o_done_irq) |-> ie_sh)
    else $error("done irq rose with enable clear");
  a_irq_stands: assert property (o_done_irq && !wr0 && !$past(wr0) |=> o_done_irq)
    else $error("done irq dropped without a write");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_power_follows: assert property (stop_sh == $past(stop_sh) |-> o_analog_power_en == !stop_sh)
    else $error("power enable disagrees with stop bit");
  a_stop_blocks: assert property (stop_sh |-> !o_sample_hold)
    else $error("sampling while stopped");
  a_start_begins: assert property (wr0 && i_wdata[CS_START] && !stop_sh && trig_sh == 3'h0 |-> ##[1:12] o_sample_hold)
    else $error("software start did not sample");
  a_len_readback: assert property ($past(rd_len) |-> o_rdata == {8'h00, $past(len_sh)})
    else $error("sample length readback wrong");
  a_sample_length: assert property ($fell(o_sample_hold) && !$past(wr0) |-> cnt == ({4'h0, eff} << ~clk_sh))
    else $error("sampling phase length wrong");
  c_irq: cover property ($rose(o_done_irq));
  c_scan_end: cover property ($rose(o_sample_hold) && o_mux_sel == 2'h3);
  c_slow: cover property ($fell(o_sample_hold) && clk_sh == 2'h0);
endmodule

bind adc_sequencer_control adc_seq_sva i_sva (.i_core_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_done_irq, .o_analog_power_en, .o_sample_hold, .o_mux_sel);

// ### adc_analog_model.sv
/*
  analog side: four input levels, internal references and a comparator.
  assumes the bench sets the input levels.
*/
`timescale 1ns/1ps
module adc_analog_model
#(
  parameter logic [39:0] REF_LEVELS = {10'h3FF, 10'h200, 10'h155, 10'h000}
)
(
  input wire logic i_core_clk,
  input wire logic i_power_en,
  input wire logic [1:0] i_mux_sel,
  input wire logic i_ref_sel,
  input wire logic [1:0] i_level_sel,
  input wire logic [9:0] i_dac_code,
  input wire logic [39:0] i_levels,
  output logic o_cmp_above
);
  logic [9:0] lvl;
  logic noise = 1'b0;
  // an unpowered comparator gives junk, so it toggles every cycle
  always @(posedge i_core_clk)
    noise <= !noise;
  // half an lsb on the input so the tie rule never matters
  always_comb
  begin
    lvl = i_ref_sel ? REF_LEVELS[i_level_sel*10 +: 10] : i_levels[i_mux_sel*10 +: 10];
    o_cmp_above = i_power_en ? ({lvl, 1'b1} > {i_dac_code, 1'b0}) : noise;
  end
endmodule

// ### adc_sequencer_control_test.sv
/*
  bench for the sequencer: register tasks note expected reads in a queue.
  assumes the analog model stands at the comparator side.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %h seen %h", nm, e, g); end end
module adc_sequencer_control_test;
  import adc_seq_pkg::*;
  localparam logic [39:0] REFS = {10'h3FF, 10'h200, 10'h155, 10'h000};
  logic i_core_clk, i_nrst, i_wr, i_rd, i_cmp_above, o_done_irq, o_analog_power_en, o_sample_hold, o_mux_ref_sel;
  logic i_ext_trigger_pin_n, i_multifunction_timer_trig, i_eight_bit_timer_trig, rd_q;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic [15:0] o_rdata, v;
  logic [1:0] o_mux_sel, o_ref_level_sel;
  logic [9:0] o_dac_code;
  logic [39:0] levels;
  logic [31:0] seed = 32'h0000002F;
  logic [31:0] note;
  logic [31:0] exp_q[$];
  int num_checks = 0;
  int fail_count = 0;
  int k, n, last;
  adc_sequencer_control i_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_ext_trigger_pin_n(i_ext_trigger_pin_n),
    .i_multifunction_timer_trig(i_multifunction_timer_trig), .i_eight_bit_timer_trig(i_eight_bit_timer_trig),
    .i_cmp_above(i_cmp_above), .o_rdata(o_rdata), .o_done_irq(o_done_irq), .o_analog_power_en(o_analog_power_en),
    .o_sample_hold(o_sample_hold), .o_mux_sel(o_mux_sel), .o_mux_ref_sel(o_mux_ref_sel),
    .o_ref_level_sel(o_ref_level_sel), .o_dac_code(o_dac_code));
  adc_analog_model #(.REF_LEVELS(REFS)) i_model (.i_core_clk(i_core_clk), .i_power_en(o_analog_power_en),
    .i_mux_sel(o_mux_sel), .i_ref_sel(o_mux_ref_sel), .i_level_sel(o_ref_level_sel), .i_dac_code(o_dac_code),
    .i_levels(levels), .o_cmp_above(i_cmp_above));
  initial
  begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  function automatic logic [9:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[9:0];
  endfunction
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  // the expectation is noted when the strobe goes out
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(posedge i_core_clk);
    v = o_rdata;
  endtask
  // bounded poll of one status bit
  task automatic poll(input int b, input logic val);
    n = 0;
    do
    begin
      reg_rd(IDX_CTRL_STATUS, 16'h0000, 16'h0000);
      n++;
    end
    while (v[b] !== val && n < 2000);
    if (v[b] !== val)
    begin
      fail_count++;
      complete_run();
    end
  endtask
  // read data stand one cycle after the strobe; compare with the oldest note
  always @(posedge i_core_clk)
  begin
    rd_q <= i_rd;
    if (rd_q && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      if (note[31:16] != 16'h0000)
        `CHK("rdata", note[15:0], o_rdata & note[31:16])
    end
  end
  initial
  begin
    {i_nrst, i_wr, i_rd, i_multifunction_timer_trig, i_eight_bit_timer_trig} = 5'h00;
    i_ext_trigger_pin_n = 1'b1;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    levels = {rnd(), rnd(), rnd(), rnd()};
    repeat (6) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    reg_rd(IDX_PLACEMENT, 16'hFFFF, {8'h00, RST_PLACEMENT});
    reg_rd(IDX_SAMPLE_LEN, 16'hFFFF, {8'h00, RST_SAMPLE_LEN});
    reg_rd(4'h7, 16'hFFFF, 16'h0000);
    reg_wr(IDX_CTRL_STATUS, 8'h20);
    reg_rd(IDX_CTRL_STATUS, 16'h0020, 16'h0000);
    `CHK("power", 1'b0, o_analog_power_en)
    reg_wr(IDX_MODULE_STOP, 8'h00);
    reg_wr(IDX_SAMPLE_LEN, 8'h03);
    $display("reset test done");
    last = 100000;
    // every post-scaler setting; a slower clock must take longer
    for (k = 0; k < 4; k++)
    begin
      levels[9:0] = rnd();
      reg_wr(IDX_CONTROL, {4'h0, k[1:0], 2'h0});
      reg_wr(IDX_CTRL_STATUS, 8'h60);
      reg_rd(IDX_CTRL_STATUS, 16'h0020, 16'h0020);
      poll(CS_START, 1'b0);
      `CHK("pace", 1'b1, n < last)
      last = n;
      `CHK("irq", 1'b1, o_done_irq)
      reg_rd(IDX_RESULT_FIRST, 16'hFFFF, {6'h00, levels[9:0]});
      reg_wr(IDX_PLACEMENT, 8'h80);
      reg_rd(IDX_RESULT_FIRST, 16'hFFFF, {levels[9:0], 6'h00});
      reg_wr(IDX_PLACEMENT, 8'h00);
      reg_wr(IDX_CTRL_STATUS, 8'h00);
    end
    $display("single test done");
    // one pass over four channels, interrupt masked
    levels = {rnd(), rnd(), rnd(), rnd()};
    reg_wr(IDX_CONTROL, 8'h0D);
    reg_wr(IDX_CTRL_STATUS, 8'h23);
    poll(CS_START, 1'b0);
    reg_rd(IDX_CTRL_STATUS, 16'h0080, 16'h0080);
    `CHK("irq", 1'b0, o_done_irq)
    for (k = 0; k < 4; k++)
      reg_rd(IDX_RESULT_FIRST + k[3:0], 16'hFFFF, {6'h00, levels[k*10 +: 10]});
    // continuous scan holds start until cleared
    reg_wr(IDX_SAMPLE_LEN, 8'h00);
    reg_wr(IDX_CONTROL, 8'h0E);
    reg_wr(IDX_CTRL_STATUS, 8'h21);
    repeat (200) @(posedge i_core_clk);
    reg_rd(IDX_CTRL_STATUS, 16'h00A0, 16'h00A0);
    reg_wr(IDX_CTRL_STATUS, 8'h00);
    poll(CS_START, 1'b0);
    reg_rd(IDX_RESULT_FIRST + 4'h1, 16'hFFFF, {6'h00, levels[19:10]});
    $display("scan test done");
    // pin, timer and eight-bit timer triggers
    for (k = 1; k < 4; k++)
    begin
      levels[9:0] = rnd();
      reg_wr(IDX_CONTROL, {k[2:0], 5'h0C});
      reg_wr(IDX_CTRL_STATUS, 8'h40);
      i_ext_trigger_pin_n <= (k != 1);
      i_multifunction_timer_trig <= (k == 2);
      i_eight_bit_timer_trig <= (k == 3);
      @(posedge i_core_clk);
      {i_multifunction_timer_trig, i_eight_bit_timer_trig} <= 2'h0;
      repeat (3) @(posedge i_core_clk);
      i_ext_trigger_pin_n <= 1'b1;
      poll(CS_DONE_FLAG, 1'b1);
      `CHK("irq", 1'b1, o_done_irq)
      reg_rd(IDX_RESULT_FIRST, 16'hFFFF, {6'h00, levels[9:0]});
      reg_wr(IDX_CTRL_STATUS, 8'h00);
    end
    $display("trigger test done");
    // self check converts reference level two
    reg_wr(IDX_SELF_CHECK, 8'h05);
    reg_wr(IDX_CONTROL, 8'h0C);
    reg_wr(IDX_CTRL_STATUS, 8'h20);
    poll(CS_START, 1'b0);
    reg_rd(IDX_RESULT_FIRST, 16'hFFFF, {6'h00, REFS[29:20]});
    $display("self check test done");
    complete_run();
  end
endmodule
